// ---- pkg/fwd_pkg.sv ----
// forwarding-mode control package: register map, fields, reset values, enums
// assumes a 32-bit axi4-lite register bus, one word per register
package fwd_pkg;
  localparam int NUM_RX = 4;
  localparam int NUM_OUT = 2;
  localparam int ADDR_W = 8;
  // printed offsets are not all multiples of four: index, byte address = 4 x index
  localparam logic [ADDR_W-1:0] FWD_PORT_CTL_IDX = 8'h20;
  localparam logic [ADDR_W-1:0] FWD_MODE_CTL_IDX = 8'h21;
  localparam logic [ADDR_W-1:0] FWD_STATE_IDX = 8'h22;
  localparam logic [7:0] FWD_PORT_CTL_RST = 8'hf0;
  localparam logic [7:0] FWD_MODE_CTL_RST = 8'h03;
  localparam int MAP_LSB = 0;
  localparam int DIS_LSB = 4;
  localparam int RR0_BIT = 0;
  localparam int RR1_BIT = 1;
  localparam int SYNC0_LSB = 2;
  localparam int SYNC1_LSB = 4;
  localparam int AS_AVAIL_BIT = 6;
  localparam int REPL_BIT = 7;
  localparam logic [1:0] AXI_OKAY = 2'b00;
  localparam logic [1:0] AXI_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    SYNC_OFF = 2'b00,
    SYNC_BASIC = 2'b01,
    SYNC_INTERLEAVE = 2'b10,
    SYNC_CONCAT = 2'b11
  } sync_mode_e;

  typedef enum logic [1:0] {
    FWD_IDLE = 2'b00,
    FWD_ROTATE = 2'b01,
    FWD_SYNC = 2'b11
  } fwd_kind_e;
endpackage

// ---- pkg/fwd_cfg_if.sv ----
// configuration bundle from the register file to the forwarding engines
// assumes one clock domain, no clocking block
`timescale 1ns/1ps
interface fwd_cfg_if;
  logic [fwd_pkg::NUM_RX-1:0] port_en;
  logic [fwd_pkg::NUM_RX-1:0] port_map;
  logic rot_en;
  fwd_pkg::sync_mode_e sync_mode;
  logic send_when_ready;
  modport src (output port_en, port_map, rot_en, sync_mode, send_when_ready);
  modport dst (input port_en, port_map, rot_en, sync_mode, send_when_ready);
endinterface

// ---- logic/fwd_engine.sv ----
// one output's forwarding engine: picks which receive port sends the next item
// assumes line requests and packet kind come from logic on the same clock
`timescale 1ns/1ps
module fwd_engine #(
  parameter int OUT_IDX = 0
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  fwd_cfg_if.dst cfg,
  input wire logic [fwd_pkg::NUM_RX-1:0] line_rdy_i,
  input wire logic [fwd_pkg::NUM_RX-1:0] line_long_i,
  input wire logic out_rdy_i,
  output logic [fwd_pkg::NUM_RX-1:0] grant_o,
  output logic synced_o
);
  import fwd_pkg::*;

  typedef struct packed {
    logic [NUM_RX-1:0] grant;
    logic [NUM_RX-1:0] last;
    logic synced;
  } eng_s;

  eng_s q, d;
  logic [NUM_RX-1:0] mine, cand, all_rdy, pick;
  logic gate_all;
  logic [2*NUM_RX-1:0] dbl;

  always_comb begin
    d = q;
    for (int i = 0; i < NUM_RX; i++) begin
      mine[i] = cfg.port_en[i] && (cfg.port_map[i] == OUT_IDX[0]);
    end
    all_rdy = mine & line_rdy_i;
    // wait on all ports unless send-when-ready covers this packet
    gate_all = (cfg.sync_mode != SYNC_OFF) && !cfg.rot_en &&
      ((cfg.sync_mode == SYNC_CONCAT) || !cfg.send_when_ready || ((mine & ~line_long_i) != '0));
    if (gate_all && (all_rdy != mine)) begin
      cand = '0;
    end else begin
      cand = all_rdy;
    end
    if (!cfg.rot_en && cfg.sync_mode == SYNC_OFF) begin
      cand = '0;
    end
    // rotating priority starting after the last served port
    // low copy: ports above the last one; high copy: every port, so rotation wraps
    dbl = {cand, cand & ~(q.last | (q.last - 1'b1))};
    pick = '0;
    for (int i = 2 * NUM_RX - 1; i >= 0; i--) begin
      if (dbl[i]) begin
        pick = '0;
        pick[i % NUM_RX] = 1'b1;
      end
    end
    d.grant = '0;
    if (out_rdy_i && cand != '0) begin
      d.grant = pick;
      d.last = pick;
    end
    d.synced = gate_all && (mine != '0) && (all_rdy == mine);
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '{grant: '0, last: {1'b1, {(NUM_RX-1){1'b0}}}, synced: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign grant_o = q.grant;
  assign synced_o = q.synced;
endmodule

// ---- logic/fwd_mode_regs.sv ----
// axi4-lite slave holding forwarding control registers
// assumes one write and one read outstanding at most
`timescale 1ns/1ps
module fwd_mode_regs (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [fwd_pkg::ADDR_W+1:0] awaddr_i,
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  input wire logic wvalid_i,
  output logic wready_o,
  output logic [1:0] bresp_o,
  output logic bvalid_o,
  input wire logic bready_i,
  input wire logic [fwd_pkg::ADDR_W+1:0] araddr_i,
  input wire logic arvalid_i,
  output logic arready_o,
  output logic [31:0] rdata_o,
  output logic [1:0] rresp_o,
  output logic rvalid_o,
  input wire logic rready_i,
  input wire logic [fwd_pkg::NUM_OUT-1:0] synced_i,
  output logic [7:0] port_ctl_o,
  output logic [7:0] mode_ctl_o
);
  import fwd_pkg::*;

  typedef struct packed {
    logic aw_got;
    logic [ADDR_W-1:0] aw_idx;
    logic w_got;
    logic [7:0] w_byte;
    logic w_lane;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [7:0] port_ctl;
    logic [7:0] mode_ctl;
    logic aw_rdy;
    logic w_rdy;
    logic ar_rdy;
  } regs_s;

  regs_s q, d;
  logic [ADDR_W-1:0] ridx;

  always_comb begin
    d = q;
    ridx = araddr_i[ADDR_W+1:2];
    if (awvalid_i && q.aw_rdy) begin
      d.aw_got = 1'b1;
      d.aw_idx = awaddr_i[ADDR_W+1:2];
    end
    if (wvalid_i && q.w_rdy) begin
      d.w_got = 1'b1;
      d.w_byte = wdata_i[7:0];
      d.w_lane = wstrb_i[0];
    end
    if (q.aw_got && q.w_got) begin
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = AXI_OKAY;
      if (q.aw_idx == FWD_PORT_CTL_IDX) begin
        if (q.w_lane) d.port_ctl = q.w_byte;
      end else if (q.aw_idx == FWD_MODE_CTL_IDX) begin
        if (q.w_lane) d.mode_ctl = q.w_byte;
      end else if (q.aw_idx != FWD_STATE_IDX) begin
        d.bresp = AXI_SLVERR;
      end
    end
    if (q.bvalid && bready_i) begin
      d.bvalid = 1'b0;
    end
    if (arvalid_i && q.ar_rdy) begin
      d.rvalid = 1'b1;
      d.rresp = AXI_OKAY;
      d.rdata = '0;
      case (ridx)
        FWD_PORT_CTL_IDX: d.rdata[7:0] = q.port_ctl;
        FWD_MODE_CTL_IDX: d.rdata[7:0] = q.mode_ctl;
        FWD_STATE_IDX: d.rdata[NUM_OUT-1:0] = synced_i;
        default: d.rresp = AXI_SLVERR;
      endcase
    end else if (q.rvalid && rready_i) begin
      d.rvalid = 1'b0;
    end
    // readies held in flops so the bus outputs come straight from state
    d.aw_rdy = !d.aw_got && !d.bvalid;
    d.w_rdy = !d.w_got && !d.bvalid;
    d.ar_rdy = !d.rvalid;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '{port_ctl: FWD_PORT_CTL_RST, mode_ctl: FWD_MODE_CTL_RST, default: '0};
    end else begin
      q <= d;
    end
  end

  assign awready_o = q.aw_rdy;
  assign wready_o = q.w_rdy;
  assign bvalid_o = q.bvalid;
  assign bresp_o = q.bresp;
  assign arready_o = q.ar_rdy;
  assign rvalid_o = q.rvalid;
  assign rdata_o = q.rdata;
  assign rresp_o = q.rresp;
  assign port_ctl_o = q.port_ctl;
  assign mode_ctl_o = q.mode_ctl;
endmodule

// ---- logic/fwd_mode_ctrl.sv ----
// top of forwarding-mode control: registers, two engines, output steering
// assumes line-ready and packet-kind inputs come from same-clock receive logic
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps
// What this block does
// - With replicate set, output 1 carries exactly the stream produced for output 0.
// - In synchronized mode without send-when-ready, a line waits until every enabled port mapped to that output is ready.
// - With send-when-ready set, each port's line goes as soon as it is ready, on both outputs.
// - Send-when-ready is ignored in concatenation and never affects sync packets.
// - Bits 5:4 pick output 1's synchronized mode: off, basic, interleave, concatenate.
// - Bits 3:2 pick output 0's synchronized mode with the same encoding.
// - Bit 1 enables rotating best-effort forwarding on output 1.
// - Bit 0 enables rotating best-effort forwarding on output 0.
// - Best-effort mode does not synchronize and serves ready sources in rotation.
// - After reset the mode register reads 0x03: rotation on, everything else off.
// - A port forwards only while its disable bit is clear; all disables reset set.
// - A per-port map bit sends the port to output 0 when clear, output 1 when set.
module fwd_mode_ctrl (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [fwd_pkg::ADDR_W+1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [fwd_pkg::ADDR_W+1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic [fwd_pkg::NUM_RX-1:0] line_rdy_i,
  input wire logic [fwd_pkg::NUM_RX-1:0] line_long_i,
  input wire logic [fwd_pkg::NUM_OUT-1:0] out_rdy_i,
  output logic [fwd_pkg::NUM_RX-1:0] out0_grant_o,
  output logic [fwd_pkg::NUM_RX-1:0] out1_grant_o,
  output logic out1_is_copy_o,
  output logic [fwd_pkg::NUM_OUT-1:0] synced_o,
  output logic [1:0] out0_kind_o,
  output logic [1:0] out1_kind_o
);
  import fwd_pkg::*;

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  typedef struct packed {
    logic [NUM_RX-1:0] g0;
    logic [NUM_RX-1:0] g1;
    logic copy;
    logic [NUM_OUT-1:0] synced;
    fwd_kind_e k0;
    fwd_kind_e k1;
  } top_s;

  top_s q, d;
  // synchroniser kept apart: it is the only state on the raw reset
  logic [1:0] rst_sync_q;
  logic rst_n;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0] port_ctl, mode_ctl;
  logic [NUM_OUT-1:0] eng_synced;
  logic [NUM_RX-1:0] eng_grant [NUM_OUT];

  fwd_mode_regs u_regs (
    .clk_i(ref_clk_i),
    .rst_n_i(rst_n),
    .awaddr_i(s_axi_awaddr_i),
    .awvalid_i(s_axi_awvalid_i),
    .awready_o(s_axi_awready_o),
    .wdata_i(s_axi_wdata_i),
    .wstrb_i(s_axi_wstrb_i),
    .wvalid_i(s_axi_wvalid_i),
    .wready_o(s_axi_wready_o),
    .bresp_o(s_axi_bresp_o),
    .bvalid_o(s_axi_bvalid_o),
    .bready_i(s_axi_bready_i),
    .araddr_i(s_axi_araddr_i),
    .arvalid_i(s_axi_arvalid_i),
    .arready_o(s_axi_arready_o),
    .rdata_o(s_axi_rdata_o),
    .rresp_o(s_axi_rresp_o),
    .rvalid_o(s_axi_rvalid_o),
    .rready_i(s_axi_rready_i),
    .synced_i(q.synced),
    .port_ctl_o(port_ctl),
    .mode_ctl_o(mode_ctl)
  );

  // ----------------------------------------
  // per-output engines
  // ----------------------------------------
  logic [NUM_OUT-1:0] rot_bits;
  logic [1:0] sync_sel [NUM_OUT];
  logic repl;

  assign rot_bits = {mode_ctl[RR1_BIT], mode_ctl[RR0_BIT]};
  assign sync_sel[0] = mode_ctl[SYNC0_LSB+:2];
  assign sync_sel[1] = mode_ctl[SYNC1_LSB+:2];
  assign repl = mode_ctl[REPL_BIT];

  generate
    for (genvar o = 0; o < NUM_OUT; o++) begin : g_out
      fwd_cfg_if cfg ();
      assign cfg.port_en = ~port_ctl[DIS_LSB+:NUM_RX];
      // under replicate every port feeds output 0
      assign cfg.port_map = repl ? '0 : port_ctl[MAP_LSB+:NUM_RX];
      assign cfg.rot_en = rot_bits[o];
      assign cfg.sync_mode = sync_mode_e'(sync_sel[o]);
      assign cfg.send_when_ready = mode_ctl[AS_AVAIL_BIT];
      fwd_engine #(
        .OUT_IDX(o)
      ) u_eng (
        .clk_i(ref_clk_i),
        .rst_n_i(rst_n),
        .cfg(cfg),
        .line_rdy_i(line_rdy_i),
        .line_long_i(line_long_i),
        .out_rdy_i(o == 0 && repl ? &out_rdy_i : out_rdy_i[o]),
        .grant_o(eng_grant[o]),
        .synced_o(eng_synced[o])
      );
    end
  endgenerate

  // ----------------------------------------
  // output steering
  // ----------------------------------------
  function automatic fwd_kind_e kind_of(input logic rot, input logic [1:0] sel);
    if (rot) begin
      return FWD_ROTATE;
    end else if (sel != SYNC_OFF) begin
      return FWD_SYNC;
    end
    return FWD_IDLE;
  endfunction

  always_comb begin
    d = q;
    d.g0 = eng_grant[0];
    d.copy = repl;
    d.k0 = kind_of(rot_bits[0], sync_sel[0]);
    d.synced[0] = eng_synced[0];
    if (repl) begin
      d.g1 = eng_grant[0];
      d.k1 = d.k0;
      d.synced[1] = eng_synced[0];
    end else begin
      d.g1 = eng_grant[1];
      d.k1 = kind_of(rot_bits[1], sync_sel[1]);
      d.synced[1] = eng_synced[1];
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      q <= '{g0: '0, g1: '0, copy: 1'b0, synced: '0, k0: FWD_IDLE, k1: FWD_IDLE};
    end else begin
      q <= d;
    end
  end

  assign out0_grant_o = q.g0;
  assign out1_grant_o = q.g1;
  assign out1_is_copy_o = q.copy;
  assign synced_o = q.synced;
  assign out0_kind_o = q.k0;
  assign out1_kind_o = q.k1;
endmodule

// ---- tb/fwd_sink_model.sv ----
// downstream receiver model: drives the two output-ready levels
// assumes the same clock as the block
`timescale 1ns/1ps
module fwd_sink_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic slow_i,
  output logic [1:0] out_rdy_o
);
  // slow receiver stalls every other cycle
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      out_rdy_o <= 2'b00;
    end else if (slow_i) begin
      out_rdy_o <= ~out_rdy_o;
    end else begin
      out_rdy_o <= 2'b11;
    end
  end
endmodule

// ---- tb/fwd_mode_ctrl_properties.sv ----
// port-level checks of the forwarding-mode control top
// assumes it is bound into fwd_mode_ctrl, one clock domain
`timescale 1ns/1ps
module fwd_mode_ctrl_properties (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [3:0] line_rdy_i,
  input wire logic [1:0] out_rdy_i,
  input wire logic s_axi_arready_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic [3:0] out0_grant_o,
  input wire logic [3:0] out1_grant_o,
  input wire logic out1_is_copy_o,
  input wire logic [1:0] synced_o,
  input wire logic [1:0] out0_kind_o,
  input wire logic [1:0] out1_kind_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  chk_grant_onehot: assert property ($onehot0(out0_grant_o) && $onehot0(out1_grant_o))
    else $error("grant not one-hot");
  chk_grant_cause: assert property (|out0_grant_o |->
    (out0_grant_o & ~$past(line_rdy_i, 2)) == 4'h0) else $error("grant without line");
  chk_grant_ready: assert property (|out0_grant_o |-> $past(out_rdy_i[0], 2))
    else $error("grant while output busy");
  chk_copy_grant: assert property (out1_is_copy_o |-> out1_grant_o == out0_grant_o)
    else $error("copy grant differs");
  chk_rotate_unsynced: assert property (out0_kind_o == 2'b01 &&
    $past(out0_kind_o) == 2'b01 |-> !synced_o[0]) else $error("synced in rotation");
  chk_idle_quiet: assert property ((out1_kind_o == 2'b00 && !out1_is_copy_o) [*4]
    |-> out1_grant_o == 4'h0) else $error("grant on idle output");
  chk_ar_block: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("read taken while answering");
  chk_r_once: assert property (s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o)
    else $error("read answer repeated");
endmodule

bind fwd_mode_ctrl fwd_mode_ctrl_properties i_props (
  .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .line_rdy_i(line_rdy_i),
  .out_rdy_i(out_rdy_i), .s_axi_arready_o(s_axi_arready_o),
  .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i),
  .out0_grant_o(out0_grant_o), .out1_grant_o(out1_grant_o),
  .out1_is_copy_o(out1_is_copy_o), .synced_o(synced_o),
  .out0_kind_o(out0_kind_o), .out1_kind_o(out1_kind_o));

// ---- tb/fwd_mode_ctrl_test.sv ----
// self-checking bench for the forwarding-mode control top
// assumes fwd_pkg, the design files and the receiver model
`timescale 1ns/1ps
module fwd_mode_ctrl_test;
  import fwd_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W+1:0] awaddr = '0;
  logic [ADDR_W+1:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [3:0] line_rdy = 4'h0, line_long = 4'hf;
  logic slow = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, copy;
  logic [31:0] rdata;
  logic [1:0] rresp, bresp, out_rdy, synced, k0, k1;
  logic [3:0] g0, g1;
  logic [31:0] d;
  logic [1:0] r;
  int mismatches = 0;
  int tests_run = 0;

  always #4 clk = ~clk;

  fwd_mode_ctrl i_dut (
    .ref_clk_i(clk), .rst_n_i(rst_n), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .line_rdy_i(line_rdy), .line_long_i(line_long),
    .out_rdy_i(out_rdy), .out0_grant_o(g0), .out1_grant_o(g1),
    .out1_is_copy_o(copy), .synced_o(synced), .out0_kind_o(k0), .out1_kind_o(k1));

  fwd_sink_model i_sink (.clk_i(clk), .rst_n_i(rst_n), .slow_i(slow), .out_rdy_o(out_rdy));

  // ----
  // checking and closing
  // ----
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic stop_test;
    if (mismatches == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic to_fail;
    mismatches++;
    stop_test();
  endtask

  // ----
  // bus and line drivers
  // ----
  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    @(posedge clk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int i = 0; i <= 50; i++) begin
      if (i == 50) to_fail();
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        break;
      end
    end
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] idx);
    @(posedge clk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int i = 0; i <= 50; i++) begin
      if (i == 50) to_fail();
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        break;
      end
    end
    rready <= 1'b0;
  endtask

  task automatic lr(input logic [3:0] v);
    @(posedge clk);
    line_rdy <= v;
  endtask

  // wait for a grant on output o, or watch for none when e is zero
  task automatic gx(input bit o, input logic [3:0] e);
    logic [3:0] g;
    g = 4'h0;
    for (int i = 0; i < 12 && g == 4'h0; i++) begin
      @(negedge clk);
      g = o ? g1 : g0;
    end
    if (e != 4'h0 && g == 4'h0) to_fail();
    chk(32'(g), 32'(e));
  endtask

  // ----
  // scenarios
  // ----
  task automatic t_regs;
    rd(8'h21); chk(d, 32'h03);
    rd(8'h20); chk(d, 32'hf0);
    rd(8'h30); chk(32'(r), 32'(AXI_SLVERR));
    chk(d, 32'h0);
    wr(8'h30, 8'h5a);
    chk(32'(r), 32'(AXI_SLVERR));
    wr(8'h21, 8'hb4);
    chk(32'(r), 32'(AXI_OKAY));
    rd(8'h21); chk(d, 32'hb4);
  endtask

  task automatic t_rotate;
    wr(8'h20, 8'h00);
    wr(8'h21, 8'h01);
    lr(4'hf);
    for (int p = 0; p < 4; p++) begin
      gx(1'b0, 4'h1 << p);
      @(posedge clk);
      line_rdy <= line_rdy & ~(4'h1 << p);
    end
    wr(8'h21, 8'h00); lr(4'h1); gx(1'b0, 4'h0);
    lr(4'h0);
  endtask

  task automatic t_modes;
    for (int c = 0; c < 4; c++) begin
      wr(8'h21, {2'b00, 2'(c), 2'(c), 2'b00});
      repeat (3) @(negedge clk);
      chk(32'(k0), (c == 0) ? 32'h0 : 32'h3);
      chk(32'(k1), (c == 0) ? 32'h0 : 32'h3);
    end
    wr(8'h21, 8'h02); repeat (3) @(negedge clk); chk(32'(k1), 32'h1);
    wr(8'h21, 8'h0d); repeat (3) @(negedge clk); chk(32'(k0), 32'h1);
  endtask

  task automatic t_sync;
    wr(8'h20, 8'hc0);
    wr(8'h21, 8'h04);
    lr(4'h1); gx(1'b0, 4'h0);
    lr(4'h3); repeat (3) @(negedge clk); chk(32'(synced[0]), 32'h1);
    rd(8'h22);
    chk(d, 32'h1);
    lr(4'h0); wr(8'h21, 8'h44); lr(4'h2); gx(1'b0, 4'h2);
    lr(4'h0); wr(8'h21, 8'h4c); lr(4'h2); gx(1'b0, 4'h0);
    lr(4'h0); wr(8'h21, 8'h44); line_long <= 4'h0; lr(4'h2); gx(1'b0, 4'h0);
    lr(4'h0); line_long <= 4'hf;
  endtask

  task automatic t_map;
    wr(8'h20, 8'h82);
    wr(8'h21, 8'h03);
    lr(4'h2); gx(1'b1, 4'h2);
    lr(4'h8); gx(1'b0, 4'h0);
    lr(4'h0);
  endtask

  task automatic t_copy;
    slow <= 1'b1;
    wr(8'h20, 8'h00);
    wr(8'h21, 8'h81);
    repeat (3) @(negedge clk); chk(32'(copy), 32'h1);
    lr(4'h4); gx(1'b1, 4'h4);
    lr(4'h0);
    slow <= 1'b0;
  endtask

  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_regs();
    t_rotate();
    t_modes();
    t_sync();
    t_map();
    t_copy();
    stop_test();
  end
endmodule
